// ==== verilog/emc_top.sv ====
// Memory-map and external multiplexed bus control, APB register slave.
// Assumes an E clock pin of about 160 ns and a CPU that splits
// misaligned external words.
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "emc_map.svh"
module emc_top
    import emc_pkg::*;
(
    // Clock and reset
    input  wire logic            pclk,
    input  wire logic            presetn,
    // APB slave
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [11:0]     paddr,
    input  wire logic [31:0]     pwdata,
    output var  logic [31:0]     prdata,
    output var  logic            pready,
    output var  logic            pslverr,
    // Mode straps
    input  wire logic [2:0]      mode_pin,
    // Internal CPU bus
    input  wire logic            cpu_req,
    input  wire emc_pkg::emc_req_s cpu_req_info,
    output var  logic            cpu_ack,
    output var  logic [15:0]     cpu_rdata,
    output var  emc_pkg::emc_hit_s cpu_hit,
    // External multiplexed bus
    input  wire logic            bus_phase_clock,
    output var  logic            ext_busy,
    output var  logic            ext_rw,
    output var  logic            ext_narrow,
    output var  logic            low_byte_strobe_n,
    input  wire logic [7:0]      pa_in,
    output var  logic [7:0]      pa_out,
    output var  logic [7:0]      pa_oe,
    input  wire logic [7:0]      lo_in,
    output var  logic [7:0]      lo_out,
    output var  logic            lo_oe
);
    // ---------------------------------------------------------------
    // Synchronised pins
    // ---------------------------------------------------------------
    logic       e_s;
    logic [2:0] mode_s;
    logic [7:0] pa_s;
    logic [7:0] lo_s;

    emc_sync #(.W(20)) u_sync (
        .clk   (pclk),
        .rst_n (presetn),
        .d     ({bus_phase_clock, mode_pin, pa_in, lo_in}),
        .q     ({e_s, mode_s, pa_s, lo_s})
    );

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    emc_mode_e   mode_ff;
    emc_bus_e    st_ff;
    emc_req_s    req_ff;
    logic [7:0]  misc_ff;
    logic [7:0]  cfg_ff;
    logic [7:0]  pa_val_ff;
    logic [7:0]  pa_dir_ff;
    logic        locked_ff;
    logic        strap_done_ff;
    logic [1:0]  strap_cnt_ff;
    logic        e_prev_ff;
    logic [1:0]  stretch_ff;
    logic [2:0]  e_per_ff;

    function automatic emc_mode_e to_mode(input logic [2:0] m);
        unique case (m)
            3'h0:    to_mode = EMC_NORMAL_SC;
            3'h1:    to_mode = EMC_NORMAL_EXP_NARROW;
            3'h2:    to_mode = EMC_NORMAL_EXP_WIDE;
            3'h3:    to_mode = EMC_SPECIAL_SC;
            3'h4:    to_mode = EMC_SPECIAL_EXP_NARROW;
            3'h5:    to_mode = EMC_SPECIAL_EXP_WIDE;
            3'h6:    to_mode = EMC_SPECIAL_PERIPH;
            default: to_mode = EMC_NORMAL_SC;
        endcase
    endfunction

    wire is_sc      = (mode_ff == EMC_NORMAL_SC) || (mode_ff == EMC_SPECIAL_SC);
    wire is_periph  = (mode_ff == EMC_SPECIAL_PERIPH);
    wire is_exp     = !is_sc && !is_periph;
    wire is_narrow  = (mode_ff == EMC_NORMAL_EXP_NARROW) ||
                      (mode_ff == EMC_SPECIAL_EXP_NARROW);
    wire is_special = (mode_ff >= EMC_SPECIAL_SC);
    wire e_rise     = e_s && !e_prev_ff;
    wire e_fall     = !e_s && e_prev_ff;

    // ---------------------------------------------------------------
    // Address decode
    // ---------------------------------------------------------------
    function automatic emc_hit_s decode(input logic [15:0] a);
        emc_hit_s h;
        logic     in_blk;
        logic     in_reg;
        logic     port_ab;
        logic     port_e;
        h      = '0;
        in_blk = (a[15:11] == cfg_ff[`EMC_CFG_BASE_MSB:0]);
        in_reg = in_blk && (a[10:9] == 2'h0);
        port_ab = in_reg && (a[8:2] == 7'h00);
        port_e  = in_reg && (a[8:1] == 8'h04);
        // port A registers usable while mapped
        h.port_regs = port_ab && is_sc;
        // first 16 registers gone in peripheral mode
        h.reg_blk = in_reg && !(is_periph && a[8:4] == 5'h00) && !(is_exp && port_ab) &&
                    !(is_exp && cfg_ff[`EMC_CFG_EME_BIT] && port_e) && !h.port_regs;
        if (misc_ff[`EMC_MISC_SWAP_BIT]) begin
            h.lower = (a >= `EMC_LOW_SWAP_START) && misc_ff[`EMC_MISC_LOW_EN_BIT];
            h.upper = !a[15] && misc_ff[`EMC_MISC_UP_EN_BIT];
        end else begin
            h.lower = !a[15] && (a >= `EMC_LOW_ARR_START) && misc_ff[`EMC_MISC_LOW_EN_BIT];
            h.upper = a[15] && misc_ff[`EMC_MISC_UP_EN_BIT];
        end
        h.lower = h.lower && !in_reg;
        h.upper = h.upper && !in_reg;
        // external space only exists in expanded modes
        h.external = is_exp && !h.reg_blk && !h.port_regs && !h.lower && !h.upper;
        // follow space directly after the block
        h.follow = h.external && in_blk && (a[10:9] == 2'h1);
        return h;
    endfunction

    // ---------------------------------------------------------------
    // Mode strap capture and E edge detect
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_cnt_ff  <= 2'h0;
            strap_done_ff <= 1'b0;
            mode_ff       <= EMC_NORMAL_SC;
            e_prev_ff     <= 1'b0;
        end else begin
            e_prev_ff <= e_s;
            if (!strap_done_ff) begin
                strap_cnt_ff <= strap_cnt_ff + 2'h1;
                if (strap_cnt_ff == `EMC_STRAP_WAIT) begin
                    strap_done_ff <= 1'b1;
                    mode_ff       <= to_mode(mode_s);
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // APB registers
    // ---------------------------------------------------------------
    wire [7:0] idx      = paddr[9:2];
    wire       aligned  = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
    wire       pa_map   = is_sc;
    wire       known    = aligned && ((idx == `EMC_IDX_MISC) || (idx == `EMC_IDX_CFG) ||
                          (idx == `EMC_IDX_STATUS) ||
                          (pa_map && (idx == `EMC_IDX_PORT_A_VALUE ||
                                      idx == `EMC_IDX_PORT_A_DIR)));
    wire       apb_wr   = psel && penable && pready && pwrite && known;
    wire [7:0] pa_read  = (pa_val_ff & pa_dir_ff) | (pa_s & ~pa_dir_ff);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !known;
            prdata  <= 32'h0;
            if (psel && !penable && known && !pwrite) begin
                unique case (idx)
                    `EMC_IDX_PORT_A_VALUE: prdata[7:0] <= pa_read;
                    `EMC_IDX_PORT_A_DIR:   prdata[7:0] <= pa_dir_ff;
                    `EMC_IDX_MISC:         prdata[7:0] <= misc_ff;
                    `EMC_IDX_CFG:          prdata[7:0] <= cfg_ff;
                    default:               prdata[7:0] <= {2'h0, st_ff != EMC_IDLE,
                                                           locked_ff, is_special, mode_ff};
                endcase
            end
        end
    end

    // Mapping control: straps pick the enable reset value after release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            misc_ff   <= `EMC_MISC_RST_EXP;
            locked_ff <= 1'b0;
        end else if (!strap_done_ff) begin
            if (strap_cnt_ff == `EMC_STRAP_WAIT) begin
                misc_ff <= (to_mode(mode_s) == EMC_NORMAL_SC ||
                            to_mode(mode_s) == EMC_SPECIAL_SC) ?
                           `EMC_MISC_RST_SC : `EMC_MISC_RST_EXP;
            end
        end else if (apb_wr && idx == `EMC_IDX_MISC && (is_special || !locked_ff)) begin
            misc_ff   <= pwdata[7:0];
            locked_ff <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_ff    <= `EMC_CFG_RST;
            pa_val_ff <= 8'h00;
            pa_dir_ff <= 8'h00;
        end else if (apb_wr) begin
            if (idx == `EMC_IDX_CFG) begin
                cfg_ff <= pwdata[7:0];
            end
            // port A registers written while mapped
            if (idx == `EMC_IDX_PORT_A_VALUE) begin
                pa_val_ff <= pwdata[7:0];
            end
            if (idx == `EMC_IDX_PORT_A_DIR) begin
                pa_dir_ff <= pwdata[7:0];
            end
        end
    end

    // ---------------------------------------------------------------
    // CPU access and external bus sequencer
    // ---------------------------------------------------------------
    emc_hit_s hit;
    assign hit = decode(cpu_req_info.addr);
    // Narrow data path: narrow modes always, wide modes by narrow bit in follow space
    // narrow bit only in expanded wide
    wire go_narrow = is_narrow || (hit.follow && misc_ff[`EMC_MISC_NARROW_BIT]);
    // external words never misaligned, CPU splits them first
    wire go_wide   = cpu_req_info.wide && !cpu_req_info.addr[0];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff             <= EMC_IDLE;
            req_ff            <= '0;
            cpu_ack           <= 1'b0;
            cpu_rdata         <= 16'h0;
            cpu_hit           <= '0;
            stretch_ff        <= 2'h0;
            ext_busy          <= 1'b0;
            ext_rw            <= 1'b1;
            ext_narrow        <= 1'b0;
            low_byte_strobe_n <= 1'b1;
        end else begin
            cpu_ack <= 1'b0;
            unique case (st_ff)
                EMC_IDLE: begin
                    if (strap_done_ff && cpu_req && !cpu_ack) begin
                        cpu_hit   <= hit;
                        req_ff    <= cpu_req_info;
                        cpu_rdata <= 16'h0;
                        if (hit.external) begin
                            st_ff             <= EMC_ADDR;
                            ext_busy          <= 1'b1;
                            ext_rw            <= cpu_req_info.rw;
                            ext_narrow        <= go_narrow;
                            req_ff.wide       <= go_wide;
                            low_byte_strobe_n <= go_wide ? cpu_req_info.addr[0] :
                                                 !cpu_req_info.addr[0];
                            stretch_ff <= hit.follow ?
                                misc_ff[`EMC_MISC_FSTR_MSB:`EMC_MISC_FSTR_LSB] :
                                misc_ff[`EMC_MISC_XSTR_MSB:`EMC_MISC_XSTR_LSB];
                        end else begin
                            cpu_ack <= 1'b1;
                        end
                    end
                end
                EMC_ADDR: begin
                    if (e_rise) begin
                        st_ff <= EMC_DATA;
                    end
                end
                EMC_DATA: begin
                    // outputs held until stretch runs out
                    if (e_fall) begin
                        if (stretch_ff == 2'h0) begin
                            st_ff    <= EMC_IDLE;
                            ext_busy <= 1'b0;
                            ext_rw   <= 1'b1;
                            cpu_ack  <= 1'b1;
                            if (!ext_narrow) begin
                                cpu_rdata <= {pa_s, lo_s};
                            end else if (req_ff.addr[0]) begin
                                cpu_rdata <= {8'h00, pa_s};
                            end else begin
                                cpu_rdata <= {pa_s, 8'h00};
                            end
                        end else begin
                            stretch_ff <= stretch_ff - 2'h1;
                        end
                    end
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Port A and low lane pins
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pa_out <= 8'h00;
            pa_oe  <= 8'h00;
            lo_out <= 8'h00;
            lo_oe  <= 1'b0;
        end else if (is_sc) begin
            pa_out <= pa_val_ff;
            pa_oe  <= pa_dir_ff;
            lo_out <= 8'h00;
            lo_oe  <= 1'b0;
        end else begin
            lo_out <= (st_ff == EMC_DATA) ? req_ff.wdata[7:0] : req_ff.addr[7:0];
            lo_oe  <= (st_ff == EMC_ADDR) ||
                      (st_ff == EMC_DATA && !ext_rw && !ext_narrow);
            if (st_ff == EMC_DATA) begin
                pa_out <= (ext_narrow && req_ff.addr[0]) ? req_ff.wdata[7:0] :
                          req_ff.wdata[15:8];
            end else begin
                pa_out <= req_ff.addr[15:8];
            end
            pa_oe <= {8{(st_ff == EMC_ADDR) || (st_ff == EMC_DATA && !ext_rw)}};
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    // E periods spent in one external access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            e_per_ff <= 3'h0;
        end else if (st_ff == EMC_IDLE) begin
            e_per_ff <= 3'h0;
        end else if (st_ff == EMC_DATA && e_fall) begin
            e_per_ff <= e_per_ff + 3'h1;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_MISC_LOCK: assert property (
        strap_done_ff && !is_special && locked_ff |=> $stable(misc_ff)
    ) else $error("mapping control changed after lock");
    AST_ARRAY_PLACE: assert property (
        cpu_ack && cpu_hit.lower |->
        (misc_ff[7] ? req_ff.addr >= 16'h9000 :
         (req_ff.addr >= 16'h1000 && !req_ff.addr[15]))
    ) else $error("lower array hit outside its window");
    AST_STRETCH: assert property (
        st_ff == EMC_DATA && e_fall && stretch_ff == 2'h0 |=>
        cpu_ack && e_per_ff == 3'h1 + {1'b0, $past(cpu_hit.follow) ?
            misc_ff[5:4] : misc_ff[3:2]}
    ) else $error("external access length wrong");
    AST_STROBE: assert property (
        $rose(ext_busy) |-> low_byte_strobe_n == (req_ff.wide ? 1'b0 : !req_ff.addr[0])
    ) else $error("byte strobe encoding wrong");
    AST_HOLD: assert property (
        ext_busy && $past(ext_busy) |->
        $stable(ext_rw) && $stable(low_byte_strobe_n) && $stable(ext_narrow)
    ) else $error("bus controls moved during access");
    AST_NO_EXT: assert property (
        strap_done_ff && !is_exp |-> !ext_busy
    ) else $error("external access outside expanded mode");
    AST_PORT_GONE: assert property (
        psel && !penable && is_exp && paddr == 12'h000 |=> pslverr && pready
    ) else $error("port register visible in expanded mode");
    AST_NARROW: assert property (
        $rose(ext_busy) && ext_narrow |-> is_narrow || (is_exp && misc_ff[6])
    ) else $error("narrow path without cause");
    AST_PERIPH: assert property (
        cpu_ack && is_periph && cpu_hit.reg_blk |-> req_ff.addr[8:4] != 5'h00
    ) else $error("bus register mapped in peripheral mode");

    COV_STRETCHED: cover property (st_ff == EMC_DATA && e_fall && stretch_ff == 2'h3);
    COV_FOLLOW: cover property (cpu_ack && cpu_hit.follow);
    COV_MISC_WR: cover property (apb_wr && idx == `EMC_IDX_MISC);
endmodule
`default_nettype wire

// ==== verilog/emc_map.svh ====
// Register indices, field positions, reset values and map constants.
// Assumes inclusion by the package and the main module only.
`ifndef EMC_MAP_SVH
`define EMC_MAP_SVH

// ---------------------------------------------------------------
// Register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define EMC_IDX_PORT_A_VALUE 8'h00
`define EMC_IDX_PORT_A_DIR   8'h02
`define EMC_IDX_MISC         8'h13
`define EMC_IDX_CFG          8'h14
`define EMC_IDX_STATUS       8'h15

// ---------------------------------------------------------------
// Mapping control fields and reset values
// ---------------------------------------------------------------
`define EMC_MISC_SWAP_BIT    7
`define EMC_MISC_NARROW_BIT  6
`define EMC_MISC_FSTR_MSB    5
`define EMC_MISC_FSTR_LSB    4
`define EMC_MISC_XSTR_MSB    3
`define EMC_MISC_XSTR_LSB    2
`define EMC_MISC_LOW_EN_BIT  1
`define EMC_MISC_UP_EN_BIT   0
`define EMC_MISC_RST_EXP     8'h0c
`define EMC_MISC_RST_SC      8'h0f
`define EMC_CFG_EME_BIT      7
`define EMC_CFG_BASE_MSB     4
`define EMC_CFG_RST          8'h00

// ---------------------------------------------------------------
// Address map and strap wait
// ---------------------------------------------------------------
`define EMC_LOW_ARR_START    16'h1000
`define EMC_LOW_SWAP_START   16'h9000
`define EMC_STRAP_WAIT       2'h2

`endif

// ==== verilog/emc_pkg.sv ====
// Types shared by the mapping and bus control block.
// Assumes emc_map.svh sits on the include path.
package emc_pkg;
    `include "emc_map.svh"

    typedef enum logic [2:0] {
        EMC_NORMAL_SC, EMC_NORMAL_EXP_NARROW, EMC_NORMAL_EXP_WIDE,
        EMC_SPECIAL_SC, EMC_SPECIAL_EXP_NARROW, EMC_SPECIAL_EXP_WIDE,
        EMC_SPECIAL_PERIPH
    } emc_mode_e;

    typedef enum {EMC_IDLE, EMC_ADDR, EMC_DATA} emc_bus_e;

    typedef struct packed {
        logic reg_blk;
        logic port_regs;
        logic follow;
        logic lower;
        logic upper;
        logic external;
    } emc_hit_s;

    typedef struct packed {
        logic [15:0] addr;
        logic        rw;
        logic        wide;
        logic [15:0] wdata;
    } emc_req_s;
endpackage

// ==== verilog/emc_sync.sv ====
// Two-stage synchroniser for pins from outside the pclk domain.
// Assumes each bit is an independent level.
`timescale 1ns/1ps
`default_nettype none
module emc_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    logic [W-1:0] meta_ff;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= '0;
            q       <= '0;
        end else begin
            meta_ff <= d;
            q       <= meta_ff;
        end
    end
endmodule
`default_nettype wire

// ==== verification/emc_ext_mem.sv ====
// External memory model on the multiplexed bus, reads only.
// Assumes data is the latched address xor a fixed pattern.
`timescale 1ns/1ps
`default_nettype none
module emc_ext_mem (
    // Clock
    input  wire logic       pclk,
    // Block side
    input  wire logic       ext_busy,
    input  wire logic [7:0] pa_out,
    input  wire logic [7:0] pa_oe,
    input  wire logic [7:0] lo_out,
    input  wire logic       lo_oe,
    // Pin levels
    output var  logic [7:0] pa_in,
    output var  logic [7:0] lo_in
);
    logic [15:0] adr_ff = 16'h0;
    logic [15:0] mem;
    // latch address phase
    // Clocked capture, so a half-updated address lane is never latched
    always @(posedge pclk) if (ext_busy && lo_oe) adr_ff <= {pa_out, lo_out};
    // Released lines invert, so a stale value never passes
    assign mem   = ext_busy ? adr_ff ^ 16'ha55a : ~(adr_ff ^ 16'ha55a);
    assign pa_in = (pa_oe & pa_out) | (~pa_oe & mem[15:8]);
    assign lo_in = lo_oe ? lo_out : mem[7:0];
endmodule
`default_nettype wire

// ==== verification/emc_top_tb.sv ====
// Self-checking bench for the mapping and external bus block.
// Assumes the memory model answers every external read.
`timescale 1ns/1ps
`default_nettype none
module emc_top_tb;
    import emc_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        bus_phase_clock = 0, cpu_req = 0, pready, pslverr, cpu_ack;
    logic        ext_busy, ext_rw, ext_narrow, low_byte_strobe_n, lo_oe, sb, a0, nw, er;
    logic [2:0]  mode_pin = 3'h3;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [15:0] cpu_rdata;
    logic [7:0]  pa_in, pa_out, pa_oe, lo_in, lo_out;
    emc_req_s    cpu_req_info = '0;
    emc_hit_s    cpu_hit;
    int          fails = 0, cmp_count = 0, l0, l1, l3, lt;
    always #5 pclk = ~pclk;
    // E clock free running, unrelated phase
    initial #3 forever #80 bus_phase_clock = ~bus_phase_clock;
    emc_top emc_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .mode_pin, .cpu_req, .cpu_req_info, .cpu_ack,
        .cpu_rdata, .cpu_hit, .bus_phase_clock, .ext_busy, .ext_rw, .ext_narrow,
        .low_byte_strobe_n, .pa_in, .pa_out, .pa_oe, .lo_in, .lo_out, .lo_oe);
    emc_ext_mem emc_ext_mem_inst (.pclk, .ext_busy, .pa_out, .pa_oe, .lo_out, .lo_oe,
        .pa_in, .lo_in);
    // ---------------------------------------------
    // Tasks
    // ---------------------------------------------
    task automatic chk(string n, logic [15:0] e, logic [15:0] s);
        cmp_count++;
        if (s !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic hang(logic ok);
        if (ok !== 1'b1) begin
            fails++;
            close_out();
        end
    endtask
    task automatic rst(logic [2:0] m);
        presetn <= 0;
        mode_pin <= m;
        repeat (3) @(posedge pclk);
        presetn <= 1;
        repeat (5) @(posedge pclk);
    endtask
    task automatic apb(logic w, logic [11:0] a, logic [7:0] d);
        int i;
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        hang(pready);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    // Error flag folded into bit 8 of the result
    task automatic rchk(string n, logic [11:0] a, logic [15:0] e);
        apb(0, a, 8'h0);
        chk(n, e, {7'h0, er, rd[7:0]});
    endtask
    task automatic cpu(logic [15:0] a, logic wd);
        sb = 1'bx;
        nw = 1'bx;
        a0 = 1'bx;
        @(posedge bus_phase_clock);
        @(posedge pclk);
        cpu_req <= 1;
        cpu_req_info <= {a, 1'b1, wd, 16'h0};
        lt = 0;
        do begin
            @(posedge pclk);
            lt++;
            if (ext_busy === 1'b1) begin
                sb = low_byte_strobe_n;
                nw = ext_narrow;
                if (lo_oe === 1'b1) a0 = lo_out[0];
            end
        end while (cpu_ack !== 1'b1 && lt < 300);
        hang(cpu_ack);
        cpu_req <= 0;
        @(posedge pclk);
    endtask
    task automatic hchk(string n, logic [15:0] a, logic [5:0] e);
        cpu(a, 1'b1);
        chk(n, {10'h0, e}, {10'h0, cpu_hit});
    endtask
    initial begin
        rst(3'h3);
        rchk("misc sc", 12'h04c, 16'h0f);
        apb(1, 12'h04c, 8'h8f);
        hchk("swap lo", 16'h9000, 6'b000100);
        hchk("swap up", 16'h0400, 6'b000010);
        apb(1, 12'h04c, 8'h0f);
        rchk("misc rewrite", 12'h04c, 16'h0f);
        hchk("lo end", 16'h7fff, 6'b000100);
        hchk("up start", 16'h8000, 6'b000010);
        apb(1, 12'h008, 8'hf0);
        apb(1, 12'h000, 8'h3c);
        @(posedge pclk);
        chk("pa oe", 16'hf0, pa_oe);
        chk("pa out", 16'h30, pa_out & pa_oe);
        rchk("pa read", 12'h000, 16'h3a);
        rchk("unmapped", 12'h0fc, 16'h100);
        rchk("misaligned", 12'h04d, 16'h100);
        $display("test 1 done");
        rst(3'h2);
        rchk("misc exp", 12'h04c, 16'h0c);
        rchk("pa gone", 12'h000, 16'h100);
        rchk("dir gone", 12'h008, 16'h100);
        apb(1, 12'h04c, 8'h04);
        apb(1, 12'h04c, 8'h0c);
        rchk("misc lock", 12'h04c, 16'h04);
        cpu(16'h0400, 1'b1);
        l1 = lt;
        chk("rd wide", 16'ha15a, cpu_rdata);
        $display("test 2 done");
        rst(3'h5);
        apb(1, 12'h04c, 8'h00);
        hchk("ext hit", 16'h0400, 6'b000001);
        l0 = lt;
        chk("type w", 16'h0, {sb, a0});
        cpu(16'h0400, 1'b0);
        chk("rd even", 16'ha1, cpu_rdata[15:8]);
        chk("type e", 16'h2, {sb, a0});
        cpu(16'h0401, 1'b0);
        chk("rd odd", 16'h5b, cpu_rdata[7:0]);
        chk("type o", 16'h1, {sb, a0});
        apb(1, 12'h04c, 8'h0c);
        cpu(16'h0400, 1'b1);
        l3 = lt;
        chk("xstr3", 16'h1, (l3 - l0 >= 44) && (l3 - l0 <= 52));
        chk("xstr1", 16'h1, (l1 - l0 >= 12) && (l1 - l0 <= 20));
        apb(1, 12'h04c, 8'h70);
        hchk("follow", 16'h0200, 6'b001001);
        chk("narrow", 16'h1, nw);
        chk("fstr3", 16'h1, lt >= l0 + 44);
        apb(1, 12'h04c, 8'h00);
        cpu(16'h0200, 1'b1);
        chk("wide", 16'h0, nw);
        apb(1, 12'h050, 8'h01);
        hchk("moved", 16'h0a00, 6'b001001);
        hchk("left", 16'h0200, 6'b000001);
        hchk("port e kept", 16'h0808, 6'b100000);
        apb(1, 12'h050, 8'h81);
        hchk("port e gone", 16'h0808, 6'b000001);
        $display("test 3 done");
        rst(3'h6);
        hchk("periph low", 16'h0004, 6'b000000);
        hchk("periph reg", 16'h0020, 6'b100000);
        $display("test 4 done");
        rst(3'h1);
        cpu(16'h0401, 1'b0);
        chk("narrow mode", 16'h1, nw);
        chk("rd narrow", 16'h00a1, cpu_rdata);
        $display("test 5 done");
        close_out();
    end
endmodule
`default_nettype wire
